// File: design/swsm_consts.svh
`ifndef SWSM_CONSTS_SVH
`define SWSM_CONSTS_SVH

// register addresses: bank bit above the 8-bit i/o address
`define SWSM_ADDR_LVL_CTRL   9'h1e3
`define SWSM_ADDR_CMP_STATE  9'h1e4
`define SWSM_ADDR_DUTY_TRIM  9'h1eb
`define SWSM_ADDR_SYS_CTRL   8'hff

// field positions
`define SWSM_SCR_SLEEP_BIT   3
`define SWSM_SCR_STOP_BIT    0
`define SWSM_RST_LVL_MSB     5
`define SWSM_RST_LVL_LSB     4
`define SWSM_DET_LVL_MSB     2
`define SWSM_DET_LVL_LSB     0
`define SWSM_DUTY_MSB        7
`define SWSM_DUTY_LSB        6
`define SWSM_CMP_LVD_BIT     1
`define SWSM_CMP_POR_BIT     0

// reset values and codes
`define SWSM_LVL_CTRL_RST    8'h00
`define SWSM_DUTY_TRIM_RST   8'h00
`define SWSM_RDATA_NONE      8'h00
`define SWSM_RST_LVL_3V      2'h1
`define SWSM_RST_LVL_RSVD    2'h2
`define SWSM_RST_LVL_NONE    2'h3
`define SWSM_DUTY_LEN_00     10'h080
`define SWSM_DUTY_LEN_01     10'h200
`define SWSM_DUTY_LEN_10     10'h020
`define SWSM_DUTY_LEN_11     10'h008

// timing
`define SWSM_CORE_HZ         125000000
`define SWSM_WAKE_MIN_US     75
`define SWSM_WAKE_MAX_US     105
`define SWSM_WAKE_MIN_CYC    ((`SWSM_WAKE_MIN_US * (`SWSM_CORE_HZ / 1000000)))
`define SWSM_WAKE_MAX_CYC    ((`SWSM_WAKE_MAX_US * (`SWSM_CORE_HZ / 1000000)))

`endif

// File: design/swsm_duty.sv
`timescale 1ns/100ps
`include "swsm_consts.svh"
module swsm_duty (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    swsm_tick_if.dst         lp,
    input  wire logic        asleep,
    input  wire logic [1:0]  duty_code,
    output logic             monitor_on
);
    logic [9:0] off_cnt_q;

    // off time in low-power clock periods for each duty code
    function automatic logic [9:0] duty_len(input logic [1:0] code);
        case (code)
            2'h0:    duty_len = `SWSM_DUTY_LEN_00;
            2'h1:    duty_len = `SWSM_DUTY_LEN_01;
            2'h2:    duty_len = `SWSM_DUTY_LEN_10;
            default: duty_len = `SWSM_DUTY_LEN_11;
        endcase
    endfunction

    // monitor on for one period, off for the selected count; always on when awake
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            monitor_on <= 1'b1;
            off_cnt_q  <= 10'h000;
        end else if (!asleep) begin
            monitor_on <= 1'b1;
            off_cnt_q  <= 10'h000;
        end else if (lp.rise) begin
            if (monitor_on) begin
                monitor_on <= 1'b0;
                off_cnt_q  <= 10'h000;
            end else if (off_cnt_q == duty_len(duty_code) - 10'h001) begin
                monitor_on <= 1'b1;
            end else begin
                off_cnt_q <= off_cnt_q + 10'h001;
            end
        end
    end
endmodule

// File: design/swsm_edge.sv
`timescale 1ns/100ps
module swsm_edge (
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    input  wire logic   sig,
    swsm_tick_if.src    tick
);
    logic prev_q;
    logic rise_q;
    logic fall_q;

    // input is synchronous, so one stage is enough to find its edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            prev_q <= sig;
            rise_q <= sig & ~prev_q;
            fall_q <= ~sig & prev_q;
        end
    end

    assign tick.rise = rise_q;
    assign tick.fall = fall_q;
endmodule

// File: design/swsm_pkg.sv
package swsm_pkg;

    // sleep / wake sequencer states
    typedef enum logic [2:0] {
        SWSM_IDLE    = 3'b000,
        SWSM_REQ     = 3'b001,
        SWSM_HALTED  = 3'b010,
        SWSM_ASLEEP  = 3'b011,
        SWSM_WAKE_PU = 3'b100,
        SWSM_WAKE_SA = 3'b101,
        SWSM_WAKE_RL = 3'b110,
        SWSM_RESUME  = 3'b111
    } swsm_state_t;

endpackage

// File: design/swsm_tick_if.sv
`timescale 1ns/100ps
// edge pulses of a slow clock sampled on core_clk
interface swsm_tick_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface

// File: design/swsm_top.sv
`timescale 1ns/100ps
`include "swsm_consts.svh"
// Function
// - setting the sleep bit raises bus-hold request immediately
// - core samples request on its rising clock, acknowledges next rising edge
// - after acknowledge, wait a falling core clock edge, then assert power-down
// - power-down stops flash, fast oscillator, filter, bandgap; monitor runs duty-cycled
// - sleep never disables the external crystal oscillator
// - any pending unmasked interrupt wakes while the stop bit is clear, regardless of global enable; nothing else
// - wake interrupt synchronised on falling low-power clock edge
// - first rising low-power edge after that releases power-down
// - next rising low-power edge samples reset and low-voltage comparators
// - following falling low-power edge drops request; core then drops acknowledge
// - instruction after the sleep write runs before any interrupt service
// - interrupt to core running takes between 75 and 105 us
// - sleep-timer interrupt also serves as periodic interrupt when awake
// - reset level 00/01 set trip, 10 reserved, 11 no reset but readable
// - detect level 000..011 set low-voltage and flash trip, 1xx reserved
// - comparator register bit 1 shows low-voltage comparator tripped
// - comparator register bit 0 shows precise reset comparator tripped
// - monitor registers answer only with the second i/o bank selected
// - duty field bits 7:6 set off periods 128, 512, 32, 8
// - sleep is bit 3 of system control; stop bit must be clear to resume
// - sleep forces core clock to internal oscillator
// - duty field trades detector latency against power during sleep
module swsm_top #(
    parameter int WAKE_MIN_CYC = `SWSM_WAKE_MIN_CYC,
    parameter int WAKE_MAX_CYC = `SWSM_WAKE_MAX_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  io_addr,
    input  wire logic        io_bank_select,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    input  wire logic        core_clock,
    input  wire logic        lp_clk,
    input  wire logic        bus_hold_ack,
    input  wire logic        irq_pending,
    input  wire logic        sleep_timer_evt,
    input  wire logic        lvd_comp,
    input  wire logic        por_comp,
    output logic             bus_hold_request,
    output logic             power_down_strobe,
    output logic             int_osc_forced,
    output logic             isr_defer,
    output logic             sleep_timer_irq,
    output logic             monitor_enable,
    output logic      [1:0]  reset_level_sel,
    output logic      [2:0]  detect_level_sel,
    output logic             precise_supply_reset,
    output logic             wake_in_window
);

    swsm_tick_if lp_tick ();
    swsm_tick_if cpu_tick ();

    swsm_pkg::swsm_state_t state_q;
    logic [7:0]  lvl_ctrl_q;
    logic [7:0]  duty_trim_q;
    logic        sleep_q;
    logic        stop_q;
    logic        lvd_state_q;
    logic        por_state_q;
    logic        monitor_on;
    logic [16:0] wake_cnt_q;
    logic        wake_cnt_en_q;
    logic        wr_sys;
    logic        wr_lvl;
    logic        wr_duty;
    logic        wake_cause;

    ////////////////////////////////////////////////////////////////////////////
    // edge finders for the low-power clock and the core clock

    swsm_edge u_lp_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .sig      (lp_clk),
        .tick     (lp_tick.src)
    );

    swsm_edge u_cpu_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .sig      (core_clock),
        .tick     (cpu_tick.src)
    );

    swsm_duty u_duty (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .lp         (lp_tick.dst),
        .asleep     (power_down_strobe),
        .duty_code  (duty_trim_q[`SWSM_DUTY_MSB:`SWSM_DUTY_LSB]),
        .monitor_on (monitor_on)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register decode

    // monitor registers live only in the second bank
    assign wr_lvl  = io_wr && ({io_bank_select, io_addr} == `SWSM_ADDR_LVL_CTRL);
    assign wr_duty = io_wr && ({io_bank_select, io_addr} == `SWSM_ADDR_DUTY_TRIM);
    assign wr_sys  = io_wr && (io_addr == `SWSM_ADDR_SYS_CTRL);

    // only defined fields are stored, so reserved bits read zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_ctrl_q <= `SWSM_LVL_CTRL_RST;
        end else if (wr_lvl) begin
            lvl_ctrl_q <= 8'h00;
            lvl_ctrl_q[`SWSM_RST_LVL_MSB:`SWSM_RST_LVL_LSB] <=
                io_wdata[`SWSM_RST_LVL_MSB:`SWSM_RST_LVL_LSB];
            lvl_ctrl_q[`SWSM_DET_LVL_MSB:`SWSM_DET_LVL_LSB] <=
                io_wdata[`SWSM_DET_LVL_MSB:`SWSM_DET_LVL_LSB];
        end
    end

    // duty field only; low six bits are reserved
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_trim_q <= `SWSM_DUTY_TRIM_RST;
        end else if (wr_duty) begin
            duty_trim_q <= {io_wdata[`SWSM_DUTY_MSB:`SWSM_DUTY_LSB], 6'h00};
        end
    end

    // sleep and stop bits of system control; hardware clears sleep on resume
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
            stop_q  <= 1'b0;
        end else begin
            if (wr_sys) begin
                stop_q <= io_wdata[`SWSM_SCR_STOP_BIT];
            end
            if (wr_sys && io_wdata[`SWSM_SCR_SLEEP_BIT]) begin
                sleep_q <= 1'b1;
            end else if (state_q == swsm_pkg::SWSM_RESUME && cpu_tick.rise && !bus_hold_ack) begin
                sleep_q <= 1'b0;
            end else if (wr_sys) begin
                sleep_q <= 1'b0;
            end
        end
    end

    // read data is registered; unmapped addresses and wrong bank read zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= `SWSM_RDATA_NONE;
        end else if (io_rd) begin
            if ({io_bank_select, io_addr} == `SWSM_ADDR_LVL_CTRL) begin
                io_rdata <= lvl_ctrl_q;
            end else if ({io_bank_select, io_addr} == `SWSM_ADDR_CMP_STATE) begin
                io_rdata <= {6'h00, lvd_state_q, por_state_q};
            end else if ({io_bank_select, io_addr} == `SWSM_ADDR_DUTY_TRIM) begin
                io_rdata <= duty_trim_q;
            end else if (io_addr == `SWSM_ADDR_SYS_CTRL) begin
                io_rdata <= 8'h00 | ({7'h00, sleep_q} << `SWSM_SCR_SLEEP_BIT)
                                  | ({7'h00, stop_q} << `SWSM_SCR_STOP_BIT);
            end else begin
                io_rdata <= `SWSM_RDATA_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sleep / wake sequencer

    // global enable is not looked at; only an interrupt may wake
    assign wake_cause = (irq_pending || sleep_timer_evt) && !stop_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= swsm_pkg::SWSM_IDLE;
        end else begin
            unique case (state_q)
                swsm_pkg::SWSM_IDLE: begin
                    if (wr_sys && io_wdata[`SWSM_SCR_SLEEP_BIT]) begin
                        state_q <= swsm_pkg::SWSM_REQ;
                    end
                end
                swsm_pkg::SWSM_REQ: begin
                    if (bus_hold_ack) begin
                        state_q <= swsm_pkg::SWSM_HALTED;
                    end
                end
                swsm_pkg::SWSM_HALTED: begin
                    if (cpu_tick.fall) begin
                        state_q <= swsm_pkg::SWSM_ASLEEP;
                    end
                end
                swsm_pkg::SWSM_ASLEEP: begin
                    if (wake_cause && lp_tick.fall) begin
                        state_q <= swsm_pkg::SWSM_WAKE_PU;
                    end
                end
                swsm_pkg::SWSM_WAKE_PU: begin
                    if (lp_tick.rise) begin
                        state_q <= swsm_pkg::SWSM_WAKE_SA;
                    end
                end
                swsm_pkg::SWSM_WAKE_SA: begin
                    if (lp_tick.rise) begin
                        state_q <= swsm_pkg::SWSM_WAKE_RL;
                    end
                end
                swsm_pkg::SWSM_WAKE_RL: begin
                    if (lp_tick.fall) begin
                        state_q <= swsm_pkg::SWSM_RESUME;
                    end
                end
                swsm_pkg::SWSM_RESUME: begin
                    if (!bus_hold_ack && cpu_tick.rise) begin
                        state_q <= swsm_pkg::SWSM_IDLE;
                    end
                end
            endcase
        end
    end

    // request rises with the sleep write and stays until the release edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_hold_request <= 1'b0;
        end else if (state_q == swsm_pkg::SWSM_IDLE && wr_sys && io_wdata[`SWSM_SCR_SLEEP_BIT]) begin
            bus_hold_request <= 1'b1;
        end else if (state_q == swsm_pkg::SWSM_WAKE_RL && lp_tick.fall) begin
            bus_hold_request <= 1'b0;
        end
    end

    // one strobe powers down flash, fast oscillator, filter and bandgap;
    // the crystal is deliberately not on it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_down_strobe <= 1'b0;
        end else if (state_q == swsm_pkg::SWSM_HALTED && cpu_tick.fall) begin
            power_down_strobe <= 1'b1;
        end else if (state_q == swsm_pkg::SWSM_WAKE_PU && lp_tick.rise) begin
            power_down_strobe <= 1'b0;
        end
    end

    // core clock select held on the internal oscillator from entry until resume
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_osc_forced <= 1'b0;
        end else if (state_q == swsm_pkg::SWSM_HALTED && cpu_tick.fall) begin
            int_osc_forced <= 1'b1;
        end else if (state_q == swsm_pkg::SWSM_IDLE) begin
            int_osc_forced <= 1'b0;
        end
    end

    // interrupt entry is held off until the core has run one instruction
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            isr_defer <= 1'b0;
        end else if (state_q == swsm_pkg::SWSM_WAKE_RL && lp_tick.fall) begin
            isr_defer <= 1'b1;
        end else if (state_q == swsm_pkg::SWSM_RESUME && !bus_hold_ack && cpu_tick.rise) begin
            isr_defer <= 1'b0;
        end
    end

    // comparators sampled at the settle edge; live while awake, frozen while
    // powered down since the monitor is only duty-cycled then
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvd_state_q <= 1'b0;
            por_state_q <= 1'b0;
        end else if ((state_q == swsm_pkg::SWSM_WAKE_SA && lp_tick.rise) || !power_down_strobe) begin
            lvd_state_q <= lvd_comp;
            por_state_q <= por_comp;
        end
    end

    // level outputs; code 11 runs the comparator at the 3 V setting
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_level_sel  <= 2'h0;
            detect_level_sel <= 3'h0;
        end else begin
            reset_level_sel <= (lvl_ctrl_q[`SWSM_RST_LVL_MSB:`SWSM_RST_LVL_LSB] == `SWSM_RST_LVL_NONE)
                               ? `SWSM_RST_LVL_3V : lvl_ctrl_q[`SWSM_RST_LVL_MSB:`SWSM_RST_LVL_LSB];
            detect_level_sel <= lvl_ctrl_q[`SWSM_DET_LVL_MSB:`SWSM_DET_LVL_LSB];
        end
    end

    // reserved code 10 and no-reset code 11 both keep the reset quiet
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            precise_supply_reset <= 1'b0;
        end else begin
            precise_supply_reset <= por_state_q && !lvl_ctrl_q[`SWSM_RST_LVL_MSB];
        end
    end

    // timer interrupt passes through in every state; monitor duty in sleep only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_timer_irq <= 1'b0;
            monitor_enable  <= 1'b1;
        end else begin
            sleep_timer_irq <= sleep_timer_evt;
            monitor_enable  <= monitor_on;
        end
    end

    // wake latency counter: from the first cycle a wake cause is seen asleep
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt_q     <= 17'h00000;
            wake_cnt_en_q  <= 1'b0;
            wake_in_window <= 1'b0;
        end else if (state_q == swsm_pkg::SWSM_ASLEEP && wake_cause && !wake_cnt_en_q) begin
            wake_cnt_q    <= 17'h00000;
            wake_cnt_en_q <= 1'b1;
        end else if (wake_cnt_en_q && state_q == swsm_pkg::SWSM_IDLE) begin
            wake_cnt_en_q  <= 1'b0;
            wake_in_window <= (wake_cnt_q >= WAKE_MIN_CYC[16:0]) &&
                              (wake_cnt_q <= WAKE_MAX_CYC[16:0]);
        end else if (wake_cnt_en_q) begin
            wake_cnt_q <= wake_cnt_q + 17'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    a_req_on_sleep: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == swsm_pkg::SWSM_IDLE && wr_sys && io_wdata[`SWSM_SCR_SLEEP_BIT]) |=> bus_hold_request)
        else $error("bus-hold request not raised after sleep write");

    a_strobe_after_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(power_down_strobe) |-> $past(cpu_tick.fall) && bus_hold_request)
        else $error("power-down rose without core clock falling edge");

    a_wake_needs_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == swsm_pkg::SWSM_ASLEEP) ##1 (state_q == swsm_pkg::SWSM_WAKE_PU)
        |-> $past(wake_cause) && $past(lp_tick.fall))
        else $error("woke without interrupt or off a falling edge");

    a_strobe_rel_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(power_down_strobe) |-> $past(lp_tick.rise) && bus_hold_request)
        else $error("power-down released off a rising edge");

    a_cmp_sample: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == swsm_pkg::SWSM_WAKE_SA && lp_tick.rise)
        |=> lvd_state_q == $past(lvd_comp) && por_state_q == $past(por_comp))
        else $error("comparators not sampled at settle edge");

    a_req_drop_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(bus_hold_request) |-> $past(lp_tick.fall) && !power_down_strobe && isr_defer)
        else $error("request dropped off a falling edge");

    a_no_reset_hi: assert property (@(posedge core_clk) disable iff (!rst_n)
        lvl_ctrl_q[`SWSM_RST_LVL_MSB] ##1 lvl_ctrl_q[`SWSM_RST_LVL_MSB] |-> !precise_supply_reset)
        else $error("reset generated with codes 10 or 11");

    a_bank_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (io_rd && !io_bank_select && io_addr != `SWSM_ADDR_SYS_CTRL) |=> io_rdata == `SWSM_RDATA_NONE)
        else $error("monitor register answered in first bank");

    a_wake_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        wake_cnt_en_q |-> wake_cnt_q <= WAKE_MAX_CYC[16:0])
        else $error("wake took longer than the limit");

endmodule

// File: verif/sleep_wake_supply_monitor_tb.sv
`timescale 1ns/100ps
module sleep_wake_supply_monitor_tb;
    logic       core_clk, rst_n, io_bank_select, io_wr, io_rd, lp_clk;
    logic       irq_pending, sleep_timer_evt, lvd_comp, por_comp;
    logic [7:0] io_addr, io_wdata, rd_v;
    wire  [7:0] io_rdata;
    wire        core_clock, bus_hold_ack, bus_hold_request, power_down_strobe;
    wire        int_osc_forced, isr_defer, sleep_timer_irq, monitor_enable;
    wire        precise_supply_reset, wake_in_window;
    wire  [1:0] reset_level_sel;
    wire  [2:0] detect_level_sel;
    wire  [3:0] mon;
    int         errors = 0;
    int         checks = 0;
    assign mon = {power_down_strobe, bus_hold_request, isr_defer, bus_hold_ack};
    swsm_top #(.WAKE_MIN_CYC(10), .WAKE_MAX_CYC(2000)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_bank_select(io_bank_select),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .core_clock(core_clock), .lp_clk(lp_clk), .bus_hold_ack(bus_hold_ack),
        .irq_pending(irq_pending), .sleep_timer_evt(sleep_timer_evt), .lvd_comp(lvd_comp),
        .por_comp(por_comp), .bus_hold_request(bus_hold_request), .power_down_strobe(power_down_strobe),
        .int_osc_forced(int_osc_forced), .isr_defer(isr_defer), .sleep_timer_irq(sleep_timer_irq),
        .monitor_enable(monitor_enable), .reset_level_sel(reset_level_sel),
        .detect_level_sel(detect_level_sel), .precise_supply_reset(precise_supply_reset),
        .wake_in_window(wake_in_window));
    swsm_core_model u_core (.core_clock(core_clock), .bus_hold_request(bus_hold_request),
        .bus_hold_ack(bus_hold_ack));
    always #4 core_clk = ~core_clk;
    // low-power clock sped up to keep the run short; handshake waits poll, bounded at 8000 core_clk cycles
    always #2000 lp_clk = ~lp_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // one-cycle strobes, driven just after one edge and dropped just after the edge that takes them; a write
    // lets an idle edge pass so a following write never re-raises the strobe at once
    task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
        io_bank_select = b;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge core_clk) #1 io_wr = 1'b0;
        @(posedge core_clk) #1;
    endtask
    task automatic rdc(input logic b, input logic [7:0] a, input logic [7:0] e, input string n);
        io_bank_select = b;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge core_clk) #1 io_rd = 1'b0;
        @(posedge core_clk) #1 rd_v = io_rdata;
        chk(n, rd_v, e);
    endtask
    // bounded wait on one handshake line; running out ends the run
    task automatic wt(input int k, input logic v);
        int i;
        for (i = 0; i < 8000 && mon[k] !== v; i++) @(posedge core_clk) #1;
        if (i == 8000) begin
            errors++;
            $display("BAD wait %0d exp %h got timeout", k, v);
            results();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {core_clk, rst_n, io_bank_select, io_wr, io_rd, lp_clk} = 6'h00;
        // every input parked low from the start, like pins parked before sleep
        {irq_pending, sleep_timer_evt, lvd_comp, por_comp, io_addr, io_wdata} = 20'h00000;
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        chk("req", bus_hold_request, 8'h00);
        chk("strobe", power_down_strobe, 8'h00);
        chk("mon", monitor_enable, 8'h01);
        rdc(1'b1, 8'he3, 8'h00, "lvl");
        $display("reset test done");
        wr(1'b1, 8'he3, 8'h12);
        wr(1'b0, 8'he3, 8'h00);
        rdc(1'b1, 8'he3, 8'h12, "lvl");
        chk("rlev", reset_level_sel, 8'h01);
        chk("dlev", detect_level_sel, 8'h02);
        wr(1'b1, 8'he3, 8'hff);
        rdc(1'b1, 8'he3, 8'h37, "lvl");
        chk("rlev", reset_level_sel, 8'h01);
        chk("dlev", detect_level_sel, 8'h07);
        wr(1'b1, 8'heb, 8'hff);
        rdc(1'b1, 8'heb, 8'hc0, "duty");
        rdc(1'b0, 8'heb, 8'h00, "duty b0");
        lvd_comp = 1'b1;
        wr(1'b1, 8'he4, 8'hff);
        rdc(1'b1, 8'he4, 8'h02, "cmp");
        {lvd_comp, por_comp} = 2'h1;
        @(posedge core_clk) #1;
        rdc(1'b1, 8'he4, 8'h01, "cmp");
        rdc(1'b0, 8'he4, 8'h00, "cmp b0");
        chk("prst", precise_supply_reset, 8'h00);
        wr(1'b1, 8'he3, 8'h02);
        chk("prst", precise_supply_reset, 8'h01);
        sleep_timer_evt = 1'b1;
        @(posedge core_clk) #1 sleep_timer_evt = 1'b0;
        chk("stirq", sleep_timer_irq, 8'h01);
        $display("register test done");
        wr(1'b0, 8'hff, 8'h08);
        @(posedge core_clk) #1;
        chk("req", bus_hold_request, 8'h01);
        rdc(1'b0, 8'hff, 8'h08, "scr");
        wt(3, 1'b1);
        chk("ack", bus_hold_ack, 8'h01);
        chk("osc", int_osc_forced, 8'h01);
        repeat (1200) @(posedge core_clk) #1;
        chk("strobe", power_down_strobe, 8'h01);
        chk("mon", monitor_enable, 8'h00);
        irq_pending = 1'b1;
        wt(3, 1'b0);
        chk("req", bus_hold_request, 8'h01);
        wt(2, 1'b0);
        chk("defer", isr_defer, 8'h01);
        irq_pending = 1'b0;
        wt(1, 1'b0);
        @(posedge core_clk) #1;
        chk("ack", bus_hold_ack, 8'h00);
        chk("win", wake_in_window, 8'h01);
        chk("osc", int_osc_forced, 8'h00);
        chk("mon", monitor_enable, 8'h01);
        rdc(1'b0, 8'hff, 8'h00, "scr");
        $display("sleep test done");
        results();
    end
endmodule

// File: verif/swsm_core_model.sv
`timescale 1ns/100ps
// cpu core stand-in: slow core clock and the bus-hold handshake
module swsm_core_model (
    output logic      core_clock,
    input  wire logic bus_hold_request,
    output logic      bus_hold_ack
);
    logic seen_q;
    initial begin
        core_clock = 1'b0;
        bus_hold_ack = 1'b0;
        seen_q = 1'b0;
    end
    // ten core_clk periods, slow enough for the sampled edge detector;
    // runs from the internal source throughout, so sleep never stops it
    always #40 core_clock = ~core_clock;
    // ack rises on the core edge after the one that saw the request;
    // a dropped request clears ack on the first core edge that sees it
    always @(posedge core_clock) begin
        seen_q <= bus_hold_request;
        bus_hold_ack <= bus_hold_request & seen_q;
    end
endmodule
